// >>> design/fcb_branch_unit.sv
// Conditional relative branch unit testing the negative and carry flags.
// Assumes instruction words arrive synchronous to clk_sys and each accepted word
// starts its own Q1; the flags are stable while the branch sits in Q3.
`timescale 1ns/100ps
module fcb_branch_unit #(
    parameter int PC_W = fcb_pkg::PC_W_DEF
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 instr_valid,
    input  wire logic [15:0]          instr_word,
    input  wire logic [PC_W-1:0]      instr_pc,
    input  wire logic                 flag_n,
    input  wire logic                 flag_c,
    output logic                      instr_ready,
    output logic                      is_cond_branch,
    output logic [1:0]                q_phase,
    output logic                      busy,
    output logic                      pc_wr_en,
    output logic [PC_W-1:0]           pc_wr_data,
    output logic                      branch_taken,
    output logic                      instr_done,
    output logic                      flags_wr_en
);
    import fcb_pkg::*;

    typedef struct packed {
        fcb_state_t         st;
        logic [1:0]         ph;
        fcb_op_t            op;
        logic [15:0]        word;
        logic [OFS_W-1:0]   ofs;
        logic [PC_W-1:0]    base;
        logic               taken;
        logic               pc_we;
        logic [PC_W-1:0]    pc_wd;
        logic               done;
        logic               flags_we;
    } fcb_regs_t;

    fcb_regs_t       r_q;
    fcb_regs_t       r_d;
    fcb_op_t         dec_op;
    logic            accept;
    logic            cond;
    logic [PC_W-1:0] target;

    // Decode of the upper byte; any other word is not ours and is never taken.
    always_comb begin
        case (instr_word[OPC_MSB:OPC_LSB])
            OPC_NEG_SET: dec_op = OP_BRANCH_IF_NEGATIVE_SET; // RULE10
            OPC_CRY_CLR: dec_op = OP_BRANCH_ON_CARRY_CLEAR; // RULE2
            OPC_NEG_CLR: dec_op = OP_BRANCH_ON_NEGATIVE_CLEAR; // RULE4
            default: dec_op = OP_NONE;
        endcase
    end

    assign is_cond_branch = (dec_op != OP_NONE);
    assign instr_ready    = (r_q.st == ST_IDLE);
    assign accept         = instr_valid && instr_ready && is_cond_branch;

    // Flag test per opcode, evaluated in Q3.
    always_comb begin
        case (r_q.op)
            OP_BRANCH_IF_NEGATIVE_SET:   cond = flag_n; // RULE10
            OP_BRANCH_ON_CARRY_CLEAR:    cond = !flag_c; // RULE1
            OP_BRANCH_ON_NEGATIVE_CLEAR: cond = !flag_n; // RULE3
            default:                     cond = 1'b0;
        endcase
    end

    fcb_target_adder #(
        .PC_W    (PC_W)
    ) u_adder (
        .pc_base (r_q.base),
        .offset  (r_q.ofs),
        .target  (target)
    );

    always_comb begin
        r_d       = r_q;
        r_d.pc_we = 1'b0;
        r_d.done  = 1'b0;
        // Flags are never written by these branches, taken or not.
        r_d.flags_we = 1'b0; // RULE9
        case (r_q.st)
            ST_IDLE: begin
                r_d.ph = PH_Q1;
                // Q1 decode happens in the accepting clock itself.
                if (accept) begin
                    r_d.st    = ST_EXEC;
                    r_d.ph    = PH_Q2;
                    r_d.op    = dec_op;
                    r_d.word  = instr_word;
                    r_d.base  = instr_pc;
                    r_d.taken = 1'b0;
                end
            end
            ST_EXEC: begin
                case (r_q.ph)
                    PH_Q2: begin
                        // Read the offset literal from the low byte.
                        r_d.ofs = r_q.word[OFS_W-1:0]; // RULE8
                        r_d.ph  = PH_Q3;
                    end
                    PH_Q3: begin
                        // Process: the outcome shows during Q4, as a PC write or as done.
                        r_d.ph    = PH_Q4;
                        r_d.taken = cond;
                        r_d.pc_we = cond; // RULE7
                        r_d.pc_wd = cond ? target : r_q.pc_wd; // RULE6
                        r_d.done  = !cond; // RULE8
                    end
                    PH_Q4: begin
                        r_d.ph = PH_Q1;
                        if (r_q.taken) begin
                            r_d.st = ST_NOP; // RULE7
                        end else begin
                            r_d.st = ST_IDLE;
                        end
                    end
                    default: begin
                        r_d.st = ST_IDLE;
                        r_d.ph = PH_Q1;
                    end
                endcase
            end
            ST_NOP: begin
                // A whole idle instruction cycle follows a taken branch.
                r_d.ph = r_q.ph + 2'h1;
                if (r_q.ph == PH_Q3) begin
                    r_d.done = 1'b1; // RULE7
                end
                if (r_q.ph == PH_Q4) begin
                    r_d.st = ST_IDLE;
                    r_d.ph = PH_Q1;
                end
            end
            default: begin
                r_d.st = ST_IDLE;
                r_d.ph = PH_Q1;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r_q          <= '0;
            r_q.st       <= ST_IDLE;
            r_q.op       <= OP_NONE;
        end else begin
            r_q          <= r_d;
        end
    end

    assign q_phase      = r_q.ph;
    assign busy         = (r_q.st != ST_IDLE);
    assign pc_wr_en     = r_q.pc_we;
    assign pc_wr_data   = r_q.pc_wd;
    assign branch_taken = r_q.taken;
    assign instr_done   = r_q.done;
    assign flags_wr_en  = r_q.flags_we;

    // Checks on the behaviour above.
    logic            in_q3;
    logic [PC_W-1:0] exp_target;

    assign in_q3      = (r_q.st == ST_EXEC) && (r_q.ph == PH_Q3);
    assign exp_target = r_q.base + PC_W'(PC_INC)
                      + PC_W'($signed(r_q.ofs)) + PC_W'($signed(r_q.ofs));

    sequence s_taken_tail;
        (r_q.st == ST_NOP && !instr_done)[*3] ##1 (r_q.st == ST_NOP && instr_done);
    endsequence

    sequence s_fall_through;
        (instr_done && !pc_wr_en) ##1 instr_ready;
    endsequence

    chk_carry_clear_cond: assert property ( // RULE1
        @(posedge clk_sys) disable iff (!rst_n)
        (in_q3 && r_q.op == OP_BRANCH_ON_CARRY_CLEAR)
        |=> (branch_taken == !$past(flag_c)) && (pc_wr_en == !$past(flag_c)))
        else $error("carry clear branch took the wrong path");

    chk_carry_clear_dec: assert property ( // RULE2
        @(posedge clk_sys) disable iff (!rst_n)
        (instr_ready && instr_valid && instr_word[OPC_MSB:OPC_LSB] == OPC_CRY_CLR)
        |=> (r_q.st == ST_EXEC && r_q.op == OP_BRANCH_ON_CARRY_CLEAR))
        else $error("carry clear opcode not decoded");

    chk_neg_clear_cond: assert property ( // RULE3
        @(posedge clk_sys) disable iff (!rst_n)
        (in_q3 && r_q.op == OP_BRANCH_ON_NEGATIVE_CLEAR)
        |=> (branch_taken == !$past(flag_n)))
        else $error("negative clear branch took the wrong path");

    chk_neg_clear_dec: assert property ( // RULE4
        @(posedge clk_sys) disable iff (!rst_n)
        (instr_ready && instr_valid && instr_word[OPC_MSB:OPC_LSB] == OPC_NEG_CLR)
        |=> (r_q.st == ST_EXEC && r_q.op == OP_BRANCH_ON_NEGATIVE_CLEAR))
        else $error("negative clear opcode not decoded");

    chk_offset_literal: assert property ( // RULE5
        @(posedge clk_sys) disable iff (!rst_n)
        accept |-> ##2 (r_q.ofs == $past(instr_word[OFS_W-1:0], 2)))
        else $error("offset literal not read in Q2");

    chk_target_value: assert property ( // RULE6
        @(posedge clk_sys) disable iff (!rst_n)
        pc_wr_en |-> (pc_wr_data == exp_target) && (pc_wr_data[0] == r_q.base[0]))
        else $error("branch target wrong");

    chk_taken_timing: assert property ( // RULE7
        @(posedge clk_sys) disable iff (!rst_n)
        accept ##3 pc_wr_en |=> s_taken_tail)
        else $error("taken branch not followed by one idle cycle");

    chk_fall_timing: assert property ( // RULE8
        @(posedge clk_sys) disable iff (!rst_n)
        (accept ##3 !pc_wr_en) |-> s_fall_through)
        else $error("fall through not one instruction cycle");

    chk_flags_kept: assert property ( // RULE9
        @(posedge clk_sys) disable iff (!rst_n)
        busy |-> !flags_wr_en ##1 !flags_wr_en)
        else $error("branch wrote status flags");

    chk_neg_set_cond: assert property ( // RULE10
        @(posedge clk_sys) disable iff (!rst_n)
        (in_q3 && r_q.op == OP_BRANCH_IF_NEGATIVE_SET)
        |=> (branch_taken == $past(flag_n)) && (instr_done == !$past(flag_n)))
        else $error("negative set branch took the wrong path");

    chk_pc_pulse: assert property ( // RULE7
        @(posedge clk_sys) disable iff (!rst_n)
        pc_wr_en |=> !pc_wr_en && !instr_ready)
        else $error("PC write not a single Q4 pulse");

endmodule

// >>> pkg/fcb_pkg.sv
// Constants and types for the flag conditional branch unit.
// Assumes one core clock where four clocks make one instruction cycle (Q1 to Q4).
// Operation
// RULE1 - Branch on carry clear jumps when carry is zero, else falls through.
// RULE2 - Branch on carry clear is one word, upper byte 1110 0011, offset low.
// RULE3 - Branch on negative clear jumps when negative is zero, else falls through.
// RULE4 - Branch on negative clear is one word, upper byte 1110 0111, offset low.
// RULE5 - Offset is a two's complement byte, -128 to 127, doubled before adding.
// RULE6 - Taken target equals branch address plus 2 plus twice the offset.
// RULE7 - Not taken costs one cycle; taken writes PC in Q4 then idles one cycle.
// RULE8 - Not taken: decode, read literal, process, then no operation in Q4.
// RULE9 - None of these branches ever changes any status flag.
// RULE10 - Branch if negative set, upper byte 1110 0110, jumps when negative is one.
package fcb_pkg;

    localparam int          PC_W_DEF  = 21;
    localparam int          OFS_W     = 8;
    localparam int          OPC_MSB   = 15;
    localparam int          OPC_LSB   = 8;
    localparam logic [7:0]  OPC_NEG_SET = 8'he6;
    localparam logic [7:0]  OPC_CRY_CLR = 8'he3;
    localparam logic [7:0]  OPC_NEG_CLR = 8'he7;
    localparam int          PC_INC    = 2;
    localparam logic [1:0]  PH_Q1     = 2'h0;
    localparam logic [1:0]  PH_Q2     = 2'h1;
    localparam logic [1:0]  PH_Q3     = 2'h2;
    localparam logic [1:0]  PH_Q4     = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_NOP  = 2'b10
    } fcb_state_t;

    typedef enum logic [1:0] {
        OP_BRANCH_IF_NEGATIVE_SET   = 2'b00,
        OP_BRANCH_ON_CARRY_CLEAR    = 2'b01,
        OP_BRANCH_ON_NEGATIVE_CLEAR = 2'b10,
        OP_NONE                     = 2'b11
    } fcb_op_t;

endpackage

// >>> design/fcb_target_adder.sv
// Branch target adder: instruction address plus two plus twice the signed offset.
// Assumes the address is a byte address and wraps at the width of the counter.
`timescale 1ns/100ps
module fcb_target_adder #(
    parameter int PC_W = fcb_pkg::PC_W_DEF
) (
    input  wire logic [PC_W-1:0]          pc_base,
    input  wire logic [fcb_pkg::OFS_W-1:0] offset,
    output logic      [PC_W-1:0]          target
);
    import fcb_pkg::*;

    logic [PC_W-1:0] ofs_twice;
    logic [PC_W-1:0] inc;

    // The byte is sign extended first so that negative offsets reach backward.
    assign ofs_twice = {{(PC_W-OFS_W-1){offset[OFS_W-1]}}, offset, 1'b0}; // RULE5
    assign inc       = PC_W'(PC_INC);
    assign target    = pc_base + inc + ofs_twice; // RULE6

endmodule

// >>> dv/tb.sv
// Self-checking bench for the flag conditional branch unit.
// Assumes one clk_sys domain and that the unit is fed one word at a time.
`timescale 1ns/100ps
module tb;
    import fcb_pkg::*;
    localparam int PW = 21;
    typedef struct packed {
        logic          tk;
        logic [PW-1:0] tgt;
    } fcb_note_t;

    logic          clk_sys     = 1'b0;
    logic          rst_n       = 1'b0;
    logic          instr_valid = 1'b0;
    logic [15:0]   instr_word  = 16'h0000;
    logic [PW-1:0] instr_pc    = '0;
    logic          flag_n      = 1'b0;
    logic          flag_c      = 1'b0;
    logic          instr_ready, is_cond_branch, busy, pc_wr_en;
    logic          branch_taken, instr_done, flags_wr_en;
    logic [1:0]    q_phase;
    logic [PW-1:0] pc_wr_data;
    logic [PW-1:0] wr_val      = '0;
    logic [7:0]    lf          = 8'h52;
    logic [7:0]    hi;
    logic [7:0]    ofs [4]     = '{8'h80, 8'h7f, 8'h00, 8'hff};
    logic [7:0]    opc [3]     = '{OPC_NEG_SET, OPC_CRY_CLR, OPC_NEG_CLR};
    fcb_note_t     notes[$];
    fcb_note_t     nt;
    int            num_errors  = 0;
    int            num_checks  = 0;
    int            cyc         = 0;
    int            acc_cyc     = 0;
    int            wr_cyc      = 0;
    int            k;

    always #2 clk_sys = ~clk_sys;

    fcb_branch_unit #(.PC_W(PW)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_pc(instr_pc), .flag_n(flag_n),
        .flag_c(flag_c), .instr_ready(instr_ready), .is_cond_branch(is_cond_branch),
        .q_phase(q_phase), .busy(busy), .pc_wr_en(pc_wr_en), .pc_wr_data(pc_wr_data),
        .branch_taken(branch_taken), .instr_done(instr_done), .flags_wr_en(flags_wr_en));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    // Waits for idle before touching the flags, since they are sampled late.
    task automatic send(input logic [15:0] w, input logic [PW-1:0] pc, input logic n, c);
        int        t;
        logic      br;
        fcb_note_t e;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (instr_ready !== 1'b1 && t < 40);
        if (t >= 40) begin
            num_errors++;
            wrap_up();
        end
        instr_valid <= 1'b1;
        instr_word <= w;
        instr_pc <= pc;
        flag_n <= n;
        flag_c <= c;
        br = w[15:8] inside {OPC_NEG_SET, OPC_CRY_CLR, OPC_NEG_CLR};
        e.tgt = pc + PW'(PC_INC) + {{(PW-9){w[7]}}, w[7:0], 1'b0};
        e.tk = (w[15:8] == OPC_NEG_SET) ? n : (w[15:8] == OPC_CRY_CLR) ? ~c : ~n;
        @(posedge clk_sys);
        check(is_cond_branch, br);
        instr_valid <= 1'b0;
        if (br) notes.push_back(e);
    endtask

    // Completion monitor: pairs each done pulse with the oldest note.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rst_n && instr_valid && instr_ready && is_cond_branch) acc_cyc <= cyc;
        if (pc_wr_en === 1'b1) begin
            wr_cyc <= cyc;
            wr_val <= pc_wr_data;
        end
        if (instr_done === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                nt = notes.pop_front();
                check(branch_taken, nt.tk);
                check(cyc - acc_cyc, nt.tk ? 7 : 3);
                check(instr_ready, 1'b0);
                check(busy, 1'b1);
                check(q_phase, PH_Q4);
                check(flags_wr_en, 1'b0);
                if (nt.tk) begin
                    check(wr_val, nt.tgt);
                    check(cyc - wr_cyc, 4);
                end else begin
                    check(wr_cyc < acc_cyc, 1'b1);
                    check(pc_wr_data, wr_val);
                end
            end
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (opc[i]) foreach (ofs[j]) for (int f = 0; f < 4; f++) begin
            send({opc[i], ofs[j]}, j[0] ? 21'h1ffffe : 21'h000100, f[0], f[1]);
        end
        send(16'he205, 21'h000040, 1'b0, 1'b1);
        for (int r = 0; r < 60; r++) begin
            lf = lfsr(lf);
            hi = (lf[1:0] == 2'h3) ? lfsr(lf) : opc[lf[1:0]];
            lf = lfsr(lfsr(lf));
            send({hi, lfsr(lf)}, {lf[4:0], lfsr(lfsr(lf)), lf}, lf[6], lf[7]);
        end
        // A reset in mid-instruction must drop the branch cleanly.
        send({OPC_NEG_SET, 8'h10}, 21'h000200, 1'b1, 1'b0);
        rst_n <= 1'b0;
        notes.delete();
        repeat (2) @(posedge clk_sys);
        check(busy, 1'b0);
        check(pc_wr_data, 21'h0);
        rst_n <= 1'b1;
        send({OPC_CRY_CLR, 8'hfe}, 21'h000300, 1'b0, 1'b0);
        k = 0;
        while (notes.size() != 0 && k < 50) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 50) num_errors++;
        repeat (4) @(posedge clk_sys);
        wrap_up();
    end
endmodule
